// file: rtl/svi_top.sv
// Single-vector interrupt unit: enables, request, entry and return sequences
`timescale 1ns/1ps
module svi_top (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   // Register port
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic [7:0]       o_reg_rdata,
   // Peripheral events
   input  wire logic        i_pwm_ovf_evt,
   input  wire logic        i_t0_match_evt,
   input  wire logic        i_port0_pin0_ext_irq,
   input  wire logic        i_port0_pin1_ext_irq,
   // CPU side
   input  wire logic        i_instr_end,
   input  wire logic        i_global_irq_on_instr,
   input  wire logic        i_global_irq_off_instr,
   input  wire logic        i_return_from_irq_instr,
   input  wire logic [15:0] i_cpu_pc,
   input  wire logic [7:0]  i_cpu_flags,
   input  wire logic [7:0]  i_stk_rdata,
   input  wire logic [7:0]  i_vec_rdata,
   output logic             o_irq_req,
   output logic             o_irq_ack,
   output logic             o_busy,
   output logic             o_stk_push,
   output logic             o_stk_pop,
   output logic [7:0]       o_stk_wdata,
   output logic             o_vec_rd,
   output logic [15:0]      o_vec_addr,
   output logic             o_branch,
   output logic [15:0]      o_branch_addr,
   output logic             o_ret,
   output logic [15:0]      o_ret_pc,
   output logic [7:0]       o_ret_flags,
   output logic             o_global_irq_enable
);
   svi_src_if src ();

   svi_pkg::svi_state_t state_ff;

   logic        gie_ff;
   logic [1:0]  page_ff;
   logic [3:0]  src_en_ff;
   logic        irq_req_ff;
   logic        irq_ack_ff;
   logic        busy_ff;
   logic        stk_push_ff;
   logic        stk_pop_ff;
   logic [7:0]  stk_wdata_ff;
   logic        vec_rd_ff;
   logic [15:0] vec_addr_ff;
   logic        branch_ff;
   logic [15:0] branch_addr_ff;
   logic        ret_ff;
   logic [15:0] ret_pc_ff;
   logic [7:0]  ret_flags_ff;
   logic [15:0] saved_pc_ff;
   logic [7:0]  saved_flags_ff;
   logic [7:0]  vec_hi_ff;
   logic [7:0]  pop_flags_ff;
   logic [7:0]  pop_pch_ff;

   logic        mode_wr;
   logic        en_wr;
   logic [3:0]  pend_clr;
   logic [7:0]  mode_val;
   logic        accept;
   logic        ret_start;
   logic        ret_done;

   assign src.src_event[svi_pkg::SRC_PWM_OVF]  = i_pwm_ovf_evt;
   assign src.src_event[svi_pkg::SRC_T0_MATCH] = i_t0_match_evt;
   assign src.src_event[svi_pkg::SRC_P0_PIN0]  = i_port0_pin0_ext_irq;
   assign src.src_event[svi_pkg::SRC_P0_PIN1]  = i_port0_pin1_ext_irq;
   assign src.src_en   = src_en_ff;
   assign src.pend_clr = pend_clr;

   svi_pend_bank u_pend (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .src        (src.bank)
   );

   always_comb begin
      mode_val = 8'h00;
      mode_val[svi_pkg::GIE_BIT] = gie_ff;
      mode_val[svi_pkg::PAGE_LSB +: svi_pkg::PAGE_W] = page_ff;
   end

   svi_reg_port u_regs (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_addr     (i_reg_addr),
      .i_wdata    (i_reg_wdata),
      .i_wr       (i_reg_wr),
      .i_rd       (i_reg_rd),
      .i_mode_val (mode_val),
      .i_en_val   (src_en_ff),
      .i_pend_val (src.pend),
      .o_mode_wr  (mode_wr),
      .o_en_wr    (en_wr),
      .o_pend_clr (pend_clr),
      .o_rdata    (o_reg_rdata)
   );

   assign accept    = (state_ff == svi_pkg::ST_IDLE) && i_instr_end && gie_ff && src.hit;
   assign ret_start = (state_ff == svi_pkg::ST_IDLE) && !accept && i_return_from_irq_instr;
   assign ret_done  = (state_ff == svi_pkg::ST_RET);

   // Global enable and page select
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         gie_ff  <= svi_pkg::GIE_RST;
         page_ff <= svi_pkg::PAGE_RST;
      end else begin
         if (accept) begin
            gie_ff <= 1'b0;
         end else if (ret_done) begin
            gie_ff <= 1'b1;
         end else if (i_global_irq_off_instr) begin
            gie_ff <= 1'b0;
         end else if (i_global_irq_on_instr) begin
            gie_ff <= 1'b1;
         end else if (mode_wr) begin
            gie_ff <= i_reg_wdata[svi_pkg::GIE_BIT];
         end
         if (mode_wr) begin
            page_ff <= i_reg_wdata[svi_pkg::PAGE_LSB +: svi_pkg::PAGE_W];
         end
      end
   end

   // Source enables
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         src_en_ff <= svi_pkg::EN_RST;
      end else if (en_wr) begin
         src_en_ff <= i_reg_wdata[3:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         irq_req_ff <= 1'b0;
      end else begin
         irq_req_ff <= gie_ff && src.hit;
      end
   end

   // Entry and return sequencer
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_ff       <= svi_pkg::ST_IDLE;
         irq_ack_ff     <= 1'b0;
         busy_ff        <= 1'b0;
         stk_push_ff    <= 1'b0;
         stk_pop_ff     <= 1'b0;
         stk_wdata_ff   <= 8'h00;
         vec_rd_ff      <= 1'b0;
         vec_addr_ff    <= 16'h0000;
         branch_ff      <= 1'b0;
         branch_addr_ff <= 16'h0000;
         ret_ff         <= 1'b0;
         ret_pc_ff      <= 16'h0000;
         ret_flags_ff   <= 8'h00;
         saved_pc_ff    <= 16'h0000;
         saved_flags_ff <= 8'h00;
         vec_hi_ff      <= 8'h00;
         pop_flags_ff   <= 8'h00;
         pop_pch_ff     <= 8'h00;
      end else begin
         irq_ack_ff  <= 1'b0;
         stk_push_ff <= 1'b0;
         stk_pop_ff  <= 1'b0;
         vec_rd_ff   <= 1'b0;
         branch_ff   <= 1'b0;
         ret_ff      <= 1'b0;
         case (state_ff)
            svi_pkg::ST_IDLE: begin
               if (accept) begin
                  irq_ack_ff     <= 1'b1;
                  busy_ff        <= 1'b1;
                  saved_pc_ff    <= i_cpu_pc;
                  saved_flags_ff <= i_cpu_flags;
                  state_ff       <= svi_pkg::ST_PUSH_LO;
               end else if (ret_start) begin
                  busy_ff  <= 1'b1;
                  state_ff <= svi_pkg::ST_POP_FL;
               end
            end
            svi_pkg::ST_PUSH_LO: begin
               stk_push_ff  <= 1'b1;
               stk_wdata_ff <= saved_pc_ff[7:0];
               state_ff     <= svi_pkg::ST_PUSH_HI;
            end
            svi_pkg::ST_PUSH_HI: begin
               stk_push_ff  <= 1'b1;
               stk_wdata_ff <= saved_pc_ff[15:8];
               state_ff     <= svi_pkg::ST_PUSH_FL;
            end
            svi_pkg::ST_PUSH_FL: begin
               stk_push_ff  <= 1'b1;
               stk_wdata_ff <= saved_flags_ff;
               state_ff     <= svi_pkg::ST_VEC_HI;
            end
            svi_pkg::ST_VEC_HI: begin
               vec_rd_ff   <= 1'b1;
               vec_addr_ff <= svi_pkg::VEC_HI_ADDR;
               state_ff    <= svi_pkg::ST_VEC_LO;
            end
            svi_pkg::ST_VEC_LO: begin
               vec_rd_ff   <= 1'b1;
               vec_addr_ff <= svi_pkg::VEC_LO_ADDR;
               state_ff    <= svi_pkg::ST_VEC_CAP;
            end
            svi_pkg::ST_VEC_CAP: begin
               vec_hi_ff <= i_vec_rdata;
               state_ff  <= svi_pkg::ST_VEC_BR;
            end
            svi_pkg::ST_VEC_BR: begin
               branch_ff      <= 1'b1;
               branch_addr_ff <= {vec_hi_ff, i_vec_rdata};
               busy_ff        <= 1'b0;
               state_ff       <= svi_pkg::ST_IDLE;
            end
            svi_pkg::ST_POP_FL: begin
               stk_pop_ff <= 1'b1;
               state_ff   <= svi_pkg::ST_POP_HI;
            end
            svi_pkg::ST_POP_HI: begin
               stk_pop_ff <= 1'b1;
               state_ff   <= svi_pkg::ST_POP_LO;
            end
            svi_pkg::ST_POP_LO: begin
               stk_pop_ff   <= 1'b1;
               pop_flags_ff <= i_stk_rdata;
               state_ff     <= svi_pkg::ST_POP_CAP;
            end
            svi_pkg::ST_POP_CAP: begin
               pop_pch_ff <= i_stk_rdata;
               state_ff   <= svi_pkg::ST_RET;
            end
            svi_pkg::ST_RET: begin
               ret_ff       <= 1'b1;
               ret_pc_ff    <= {pop_pch_ff, i_stk_rdata};
               ret_flags_ff <= pop_flags_ff;
               busy_ff      <= 1'b0;
               state_ff     <= svi_pkg::ST_IDLE;
            end
            default: begin
               busy_ff  <= 1'b0;
               state_ff <= svi_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign o_irq_req           = irq_req_ff;
   assign o_irq_ack           = irq_ack_ff;
   assign o_busy              = busy_ff;
   assign o_stk_push          = stk_push_ff;
   assign o_stk_pop           = stk_pop_ff;
   assign o_stk_wdata         = stk_wdata_ff;
   assign o_vec_rd            = vec_rd_ff;
   assign o_vec_addr          = vec_addr_ff;
   assign o_branch            = branch_ff;
   assign o_branch_addr       = branch_addr_ff;
   assign o_ret               = ret_ff;
   assign o_ret_pc            = ret_pc_ff;
   assign o_ret_flags         = ret_flags_ff;
   assign o_global_irq_enable = gie_ff;
endmodule

// file: inc/svi_pkg.sv
// Constants and types shared by the single-vector interrupt unit
package svi_pkg;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned PC_W     = 16;
   localparam int unsigned NUM_SRC  = 4;

   // Register offsets
   localparam logic [7:0]  MODE_ADDR     = 8'hDF;
   localparam logic [7:0]  SRC_EN_ADDR   = 8'hF8;
   localparam logic [7:0]  SRC_PEND_ADDR = 8'hF9;

   // System mode register fields and reset values
   localparam int unsigned GIE_BIT   = 2;
   localparam int unsigned PAGE_LSB  = 0;
   localparam int unsigned PAGE_W    = 2;
   localparam logic [1:0]  PAGE_RST  = 2'h0;
   localparam logic        GIE_RST   = 1'b0;
   localparam logic [3:0]  EN_RST    = 4'h0;
   localparam logic [3:0]  PEND_RST  = 4'h0;

   // Source positions in the enable and pending registers
   localparam int unsigned SRC_PWM_OVF  = 0;
   localparam int unsigned SRC_T0_MATCH = 1;
   localparam int unsigned SRC_P0_PIN0  = 2;
   localparam int unsigned SRC_P0_PIN1  = 3;

   // Shared vector location
   localparam logic [15:0] VEC_HI_ADDR = 16'h0000;
   localparam logic [15:0] VEC_LO_ADDR = 16'h0001;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_PUSH_LO,
      ST_PUSH_HI,
      ST_PUSH_FL,
      ST_VEC_HI,
      ST_VEC_LO,
      ST_VEC_CAP,
      ST_VEC_BR,
      ST_POP_FL,
      ST_POP_HI,
      ST_POP_LO,
      ST_POP_CAP,
      ST_RET
   } svi_state_t;
endpackage

// file: inc/svi_src_if.sv
// Source flag bundle between the control core and the pending bank
`timescale 1ns/1ps
interface svi_src_if;
   logic [3:0] src_event;
   logic [3:0] src_en;
   logic [3:0] pend_clr;
   logic [3:0] pend;
   logic       hit;

   modport bank (
      input  src_event,
      input  src_en,
      input  pend_clr,
      output pend,
      output hit
   );
   modport ctl (
      output src_event,
      output src_en,
      output pend_clr,
      input  pend,
      input  hit
   );
endinterface

// file: rtl/svi_pend_bank.sv
// Pending flags for the interrupt sources
`timescale 1ns/1ps
module svi_pend_bank (
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   svi_src_if.bank   src
);
   logic [3:0] pend_ff;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_src
         always_ff @(posedge i_core_clk) begin
            if (i_reset) begin
               pend_ff[g] <= svi_pkg::PEND_RST[g];
            end else if (src.src_event[g]) begin
               pend_ff[g] <= 1'b1;
            end else if (src.pend_clr[g]) begin
               pend_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign src.pend = pend_ff;
   assign src.hit  = |(pend_ff & src.src_en);
endmodule

// file: rtl/svi_reg_port.sv
// Register port decode and registered read data
`timescale 1ns/1ps
module svi_reg_port (
   input  wire logic       i_core_clk,
   input  wire logic       i_reset,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_mode_val,
   input  wire logic [3:0] i_en_val,
   input  wire logic [3:0] i_pend_val,
   output logic            o_mode_wr,
   output logic            o_en_wr,
   output logic [3:0]      o_pend_clr,
   output logic [7:0]      o_rdata
);
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   assign o_mode_wr = i_wr && (i_addr == svi_pkg::MODE_ADDR);
   assign o_en_wr  = i_wr && (i_addr == svi_pkg::SRC_EN_ADDR);
   assign o_pend_clr = (i_wr && (i_addr == svi_pkg::SRC_PEND_ADDR)) ? ~i_wdata[3:0] : 4'h0;

   always_comb begin
      nxt_rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            svi_pkg::MODE_ADDR:     nxt_rdata = i_mode_val;
            svi_pkg::SRC_EN_ADDR:   nxt_rdata = {4'h0, i_en_val};
            svi_pkg::SRC_PEND_ADDR: nxt_rdata = {4'h0, i_pend_val};
            default:                nxt_rdata = 8'h00;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign o_rdata = rdata_ff;
endmodule

// file: test/svi_properties.sv
// Port-level concurrent checks for the interrupt unit
`timescale 1ns/1ps
module svi_properties (
   input wire logic        i_core_clk,
   input wire logic        i_reset,
   input wire logic        i_instr_end,
   input wire logic        i_global_irq_on_instr,
   input wire logic        i_global_irq_off_instr,
   input wire logic [15:0] i_cpu_pc,
   input wire logic [7:0]  i_cpu_flags,
   input wire logic [7:0]  i_stk_rdata,
   input wire logic [7:0]  i_vec_rdata,
   input wire logic        o_irq_req,
   input wire logic        o_irq_ack,
   input wire logic        o_busy,
   input wire logic        o_stk_push,
   input wire logic        o_stk_pop,
   input wire logic [7:0]  o_stk_wdata,
   input wire logic        o_vec_rd,
   input wire logic [15:0] o_vec_addr,
   input wire logic        o_branch,
   input wire logic [15:0] o_branch_addr,
   input wire logic        o_ret,
   input wire logic [15:0] o_ret_pc,
   input wire logic [7:0]  o_ret_flags,
   input wire logic        o_global_irq_enable
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   sequence s_pushes;
      o_stk_push && o_stk_wdata == $past(i_cpu_pc[7:0], 2) ##1
      o_stk_push && o_stk_wdata == $past(i_cpu_pc[15:8], 3) ##1
      o_stk_push && o_stk_wdata == $past(i_cpu_flags, 4);
   endsequence
   sequence s_fetch;
      o_vec_rd && o_vec_addr == 16'h0000 ##1 o_vec_rd && o_vec_addr == 16'h0001;
   endsequence

   a_entry_order:
      assert property (o_irq_ack |=> s_pushes ##1 s_fetch) else $error("entry push or fetch order wrong");
   a_ack_clears_gie:
      assert property (o_irq_ack |-> !o_global_irq_enable && o_busy) else $error("ack without enable cleared");
   a_accept_cause:
      assert property (o_irq_ack |-> $past(i_instr_end && o_global_irq_enable && !o_busy))
      else $error("ack without enabled instruction end");
   a_no_ack_off:
      assert property (!o_global_irq_enable |=> !o_irq_ack) else $error("ack while globally disabled");
   a_branch_vector:
      assert property (o_vec_rd && o_vec_addr == 16'h0001 |-> ##2 o_branch && !o_busy &&
         o_branch_addr == {$past(i_vec_rdata, 2), $past(i_vec_rdata, 1)}) else $error("branch address wrong");
   a_return_steps:
      assert property ($rose(o_busy) && !o_irq_ack |=> o_stk_pop [*3] ##2 o_ret && o_global_irq_enable && !o_busy)
      else $error("return sequence wrong");
   a_return_data:
      assert property (o_ret |-> o_ret_flags == $past(i_stk_rdata, 3) &&
         o_ret_pc == {$past(i_stk_rdata, 2), $past(i_stk_rdata, 1)}) else $error("restored state wrong");
   a_req_gated:
      assert property (o_irq_req |-> $past(o_global_irq_enable)) else $error("request without global enable");
   a_gie_on:
      assert property (i_global_irq_on_instr && !i_global_irq_off_instr && !o_busy && !o_global_irq_enable
         |=> o_global_irq_enable) else $error("enable instruction ignored");
   a_gie_off:
      assert property (i_global_irq_off_instr && !o_busy |=> !o_global_irq_enable)
      else $error("disable instruction ignored");
endmodule

bind svi_top svi_properties u_props (.i_core_clk, .i_reset, .i_instr_end, .i_global_irq_on_instr,
   .i_global_irq_off_instr, .i_cpu_pc, .i_cpu_flags, .i_stk_rdata, .i_vec_rdata, .o_irq_req, .o_irq_ack,
   .o_busy, .o_stk_push, .o_stk_pop, .o_stk_wdata, .o_vec_rd, .o_vec_addr, .o_branch, .o_branch_addr,
   .o_ret, .o_ret_pc, .o_ret_flags, .o_global_irq_enable);

// file: test/svi_cpu_model.sv
// Stack and program memory model on the CPU side
`timescale 1ns/1ps
module svi_cpu_model #(
   parameter logic [15:0] VEC = 16'hB3E6
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_stk_push,
   input  wire logic [7:0]  i_stk_wdata,
   input  wire logic        i_stk_pop,
   input  wire logic        i_vec_rd,
   input  wire logic [15:0] i_vec_addr,
   output logic [7:0]       o_stk_rdata,
   output logic [7:0]       o_vec_rdata
);
   logic [7:0]  stk [0:7];
   logic [2:0]  stk_ptr_ff = 3'h0;
   initial o_stk_rdata = 8'h00;
   initial o_vec_rdata = 8'h00;
   // Released lines show the inverse of the last byte
   always @(posedge i_core_clk) begin
      o_stk_rdata <= ~o_stk_rdata;
      if (i_stk_push) begin
         stk[stk_ptr_ff] <= i_stk_wdata;
         stk_ptr_ff      <= stk_ptr_ff + 3'h1;
      end else if (i_stk_pop) begin
         o_stk_rdata <= stk[stk_ptr_ff - 3'h1];
         stk_ptr_ff  <= stk_ptr_ff - 3'h1;
      end
   end
   always @(posedge i_core_clk) begin
      o_vec_rdata <= ~o_vec_rdata;
      // Byte stands in the cycle after the read pulse
      if (i_vec_rd) begin
         o_vec_rdata <= (i_vec_addr == 16'h0000) ? VEC[15:8] : VEC[7:0];
      end
   end
endmodule

// file: test/test_single_vector_interrupt_unit.sv
// Self-checking bench for the interrupt unit
`timescale 1ns/1ps
module test_single_vector_interrupt_unit;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [3:0]  ev = 4'h0;
   logic        iend = 1'b0;
   logic        gon = 1'b0;
   logic        goff = 1'b0;
   logic        ret_ins = 1'b0;
   logic [15:0] pc = 16'h0000;
   logic [7:0]  fl = 8'h00;
   logic [7:0]  stk_d, vec_d, rdata, stk_wd;
   logic        req, ack, busy, push, pop, vrd, br, ret, gie;
   logic [15:0] vaddr, br_addr, ret_pc;
   logic [7:0]  ret_fl;
   int          n_mismatch = 0;
   int          n_tests = 0;

   always #4 clk = ~clk;

   svi_top dut (.i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rdata), .i_pwm_ovf_evt(ev[0]), .i_t0_match_evt(ev[1]),
      .i_port0_pin0_ext_irq(ev[2]), .i_port0_pin1_ext_irq(ev[3]), .i_instr_end(iend),
      .i_global_irq_on_instr(gon), .i_global_irq_off_instr(goff), .i_return_from_irq_instr(ret_ins),
      .i_cpu_pc(pc), .i_cpu_flags(fl), .i_stk_rdata(stk_d), .i_vec_rdata(vec_d), .o_irq_req(req),
      .o_irq_ack(ack), .o_busy(busy), .o_stk_push(push), .o_stk_pop(pop), .o_stk_wdata(stk_wd),
      .o_vec_rd(vrd), .o_vec_addr(vaddr), .o_branch(br), .o_branch_addr(br_addr), .o_ret(ret),
      .o_ret_pc(ret_pc), .o_ret_flags(ret_fl), .o_global_irq_enable(gie));
   svi_cpu_model #(.VEC(16'hB3E6)) m (.i_core_clk(clk), .i_stk_push(push), .i_stk_wdata(stk_wd),
      .i_stk_pop(pop), .i_vec_rd(vrd), .i_vec_addr(vaddr), .o_stk_rdata(stk_d), .o_vec_rdata(vec_d));

   task automatic test_done;
      if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(nm, {8'h00, exp}, {8'h00, rdata});
   endtask

   task automatic pulse_ev(input logic [3:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 4'h0;
   endtask

   task automatic wait_on(input int k);
      int i;
      for (i = 0; i < 30; i++) begin
         #1;
         if ((k == 0 && ack === 1'b1) || (k == 1 && br === 1'b1) || (k == 2 && ret === 1'b1)) break;
         @(posedge clk);
      end
      if (i == 30) begin
         n_mismatch++;
         $display("[ERR] wait_on %0d expected pulse seen none", k);
         test_done();
      end
   endtask

   task automatic t_reset_values;
      reg_rd(8'hDF, 8'h00, "mode");
      reg_rd(8'hF8, 8'h00, "enables");
      reg_rd(8'hF9, 8'h00, "pending");
      reg_rd(8'h10, 8'h00, "unmapped");
   endtask

   task automatic t_pending;
      pulse_ev(4'hF);
      reg_rd(8'hF9, 8'h0F, "all pending");
      reg_wr(8'hF9, 8'hFE);
      reg_rd(8'hF9, 8'h0E, "clear one");
      pulse_ev(4'h2);
      reg_rd(8'hF9, 8'h0E, "repeat event");
      reg_wr(8'hF9, 8'h00);
      reg_rd(8'hF9, 8'h00, "clear all");
      @(posedge clk);
      ev <= 4'h4;
      addr <= 8'hF9;
      wdata <= 8'h00;
      wr <= 1'b1;
      @(posedge clk);
      ev <= 4'h0;
      wr <= 1'b0;
      reg_rd(8'hF9, 8'h04, "set beats clear");
      reg_wr(8'hF9, 8'h00);
   endtask

   task automatic t_gating;
      pulse_ev(4'h8);
      @(posedge clk);
      gon <= 1'b1;
      @(posedge clk);
      gon <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("gie on", 16'h1, {15'h0, gie});
      chk("req src off", 16'h0, {15'h0, req});
      reg_wr(8'hF8, 8'h09);
      repeat (2) @(posedge clk);
      #1;
      chk("req src on", 16'h1, {15'h0, req});
      reg_wr(8'hDF, 8'h00);
      @(posedge clk);
      iend <= 1'b1;
      @(posedge clk);
      iend <= 1'b0;
      #1;
      chk("ack while off", 16'h0, {15'h0, ack});
      reg_wr(8'hDF, 8'hFF);
      reg_rd(8'hDF, 8'h07, "mode write");
      @(posedge clk);
      goff <= 1'b1;
      @(posedge clk);
      goff <= 1'b0;
      #1;
      chk("gie off instr", 16'h0, {15'h0, gie});
      @(posedge clk);
      gon <= 1'b1;
      @(posedge clk);
      gon <= 1'b0;
      #1;
      chk("gie on instr", 16'h1, {15'h0, gie});
   endtask

   task automatic t_entry_return;
      pulse_ev(4'h1);
      @(posedge clk);
      pc <= 16'h4A7C; fl <= 8'hD5; iend <= 1'b1;
      @(posedge clk);
      iend <= 1'b0;
      wait_on(0);
      chk("gie at ack", 16'h0, {15'h0, gie});
      wait_on(1);
      chk("branch", 16'hB3E6, br_addr);
      chk("push pc lo", 16'h7C, {8'h00, m.stk[0]});
      chk("push pc hi", 16'h4A, {8'h00, m.stk[1]});
      chk("push flags", 16'hD5, {8'h00, m.stk[2]});
      reg_wr(8'hF9, 8'h00);
      @(posedge clk);
      ret_ins <= 1'b1;
      @(posedge clk);
      ret_ins <= 1'b0;
      wait_on(2);
      chk("ret pc", 16'h4A7C, ret_pc);
      chk("ret flags", 16'hD5, {8'h00, ret_fl});
      chk("gie after ret", 16'h1, {15'h0, gie});
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset_values();
      t_pending();
      t_gating();
      t_entry_return();
      repeat (3) @(posedge clk);
      test_done();
   end
endmodule
